// file: design/clcr_pkg.sv
package clcr_pkg;

    // ==========================================================
    // register map (index, byte address is four times the index)
    localparam logic [7:0] IDX_ONE = 8'h88;
    localparam logic [7:0] IDX_TWO = 8'h8A;
    localparam logic [11:0] ADDR_ONE = {2'h0, IDX_ONE, 2'h0};
    localparam logic [11:0] ADDR_TWO = {2'h0, IDX_TWO, 2'h0};
    localparam logic [31:0] RST_ONE = 32'h00000000;
    localparam logic [31:0] RST_TWO = 32'h00000000;
    localparam logic [31:0] MASK_ONE = 32'h01FFFFFE;
    localparam logic [31:0] MASK_TWO = 32'h7FFFFFFF;

    // ==========================================================
    // field positions, first register
    localparam int DEC_SEL_BIT = 24;
    localparam int DEC_LSB = 19;
    localparam int FREQ_LSB = 15;
    localparam int MODE_BIT = 14;
    localparam int GATE_LSB = 12;
    localparam int DIV_LSB = 8;
    localparam int CUT_MODE_BIT = 7;
    localparam int CUT_LVL_LSB = 4;
    localparam int SURGE_BIT = 3;
    localparam int DEAD_BIT = 2;
    localparam int TORQ_BIT = 1;

    // field positions, second register
    localparam int STOP_LSB = 28;
    localparam int BRK_LSB = 24;
    localparam int RES_LSB = 8;
    localparam int IND_LSB = 0;

    // ==========================================================
    // codes
    localparam logic [1:0] GATE_BOTH = 2'h0;
    localparam logic [1:0] GATE_CLOSED = 2'h1;
    localparam logic [1:0] GATE_FIRST = 2'h2;
    localparam logic [1:0] GATE_NONE = 2'h3;
    localparam logic [4:0] DEC_NO_LIMIT = 5'h1F;
    localparam logic [19:0] RATE_NO_LIMIT = 20'hFFFFF;
    localparam logic [2:0] CUT_LVL_MAX = 3'h5;

    typedef enum logic [2:0] {
        run_wait = 3'b001,
        run_first = 3'b010,
        run_later = 3'b100
    } clcr_run_t;

    // ==========================================================
    // deceleration code to rate in tenths of Hz/s
    function automatic logic [19:0] decel_tenths(input logic [4:0] code);
        logic [19:0] t [0:30];
        t = '{20'd5, 20'd10, 20'd25, 20'd50, 20'd75, 20'd100, 20'd200,
              20'd400, 20'd600, 20'd800, 20'd1000, 20'd2000, 20'd3000,
              20'd4000, 20'd5000, 20'd6000, 20'd7000, 20'd8000, 20'd9000,
              20'd10000, 20'd20000, 20'd40000, 20'd60000, 20'd80000,
              20'd100000, 20'd200000, 20'd300000, 20'd400000, 20'd500000,
              20'd600000, 20'd700000};
        if (code == DEC_NO_LIMIT) begin
            return RATE_NO_LIMIT;
        end
        return t[code];
    endfunction

    // cut-off code to back-emf level in mV, zero where not applicable
    function automatic logic [7:0] cutoff_mv(input logic [2:0] code);
        unique case (code)
            3'h0: return 8'h01;
            3'h1: return 8'h02;
            3'h2: return 8'h05;
            3'h3: return 8'h0A;
            3'h4: return 8'h14;
            3'h5: return 8'h1E;
            default: return 8'h00;
        endcase
    endfunction

    // merge write data under byte strobes and a writable mask
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0] strb,
                                          input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        m = m & mask;
        return ((old & ~m) | (wdata & m)) & mask;
    endfunction

endpackage

// file: design/clcr_speed_pulse.sv
`timescale 1ns/1ns
module clcr_speed_pulse (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [1:0] gate_select,
    input wire logic [3:0] divider,
    input wire logic cutoff_mode,
    input wire logic [2:0] cutoff_level,
    input wire logic motor_driven,
    input wire logic closed_loop,
    input wire logic run_start,
    input wire logic wake_event,
    input wire logic pulse_event,
    input wire logic [7:0] back_emf_mv,
    output logic speed_pulse_output
);

    typedef struct packed {
        clcr_pkg::clcr_run_t fsm;
        logic [3:0] count;
        logic pulse;
    } clcr_sp_state_t;

    clcr_sp_state_t state;
    clcr_sp_state_t next_state;
    logic gate_ok;
    logic active;
    logic [3:0] ratio;
    logic [7:0] level;

    // ==========================================================
    // gating, cut-off and division
    always_comb begin
        next_state = state;
        level = clcr_pkg::cutoff_mv(cutoff_level);
        ratio = (divider < 4'h2) ? 4'h1 : divider; // R06
        unique case (gate_select)
            clcr_pkg::GATE_BOTH: gate_ok = 1'b1; // R04
            clcr_pkg::GATE_CLOSED: gate_ok = closed_loop; // R04
            clcr_pkg::GATE_FIRST:
                gate_ok = closed_loop | (state.fsm == clcr_pkg::run_first); // R05
            clcr_pkg::GATE_NONE: gate_ok = 1'b0; // R04
        endcase
        // coasting output only while back-emf stays at or above level
        if (cutoff_mode && cutoff_level <= clcr_pkg::CUT_LVL_MAX) begin
            active = motor_driven | (back_emf_mv >= level); // R07 R08
        end else begin
            active = motor_driven; // R07
        end
        next_state.pulse = 1'b0;
        if (pulse_event && gate_ok && active) begin
            if (state.count + 4'h1 >= ratio) begin // R06
                next_state.count = 4'h0;
                next_state.pulse = 1'b1;
            end else begin
                next_state.count = state.count + 4'h1;
            end
        end
        // first-run tracking after power-up or wake
        unique case (state.fsm)
            clcr_pkg::run_wait: begin
                if (run_start) begin
                    next_state.fsm = clcr_pkg::run_first; // R05
                end
            end
            clcr_pkg::run_first: begin
                if (!motor_driven) begin
                    next_state.fsm = clcr_pkg::run_later; // R05
                end
            end
            clcr_pkg::run_later: next_state.fsm = clcr_pkg::run_later;
            default: next_state.fsm = clcr_pkg::run_wait;
        endcase
        if (wake_event) begin
            next_state.fsm = clcr_pkg::run_wait; // R05
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state.fsm <= clcr_pkg::run_wait;
            state.count <= 4'h0;
            state.pulse <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign speed_pulse_output = state.pulse;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    gate_none_a: assert property (speed_pulse_output |-> // R04
        $past(gate_select) != clcr_pkg::GATE_NONE)
        else $error("pulse with output gated off");
    closed_only_a: assert property ( // R04
        speed_pulse_output && $past(gate_select) == clcr_pkg::GATE_CLOSED
        |-> $past(closed_loop))
        else $error("pulse in open loop with closed-only gate");
    first_run_a: assert property ( // R05
        speed_pulse_output && $past(gate_select) == clcr_pkg::GATE_FIRST
        && !$past(closed_loop) |-> $past(state.fsm) == clcr_pkg::run_first)
        else $error("open loop pulse outside first run");
    div_one_a: assert property ( // R06
        pulse_event && gate_select == clcr_pkg::GATE_BOTH && motor_driven
        && divider <= 4'h1 |=> speed_pulse_output)
        else $error("divide by one dropped a pulse");
    driven_only_a: assert property ( // R07
        speed_pulse_output && !$past(cutoff_mode) |-> $past(motor_driven))
        else $error("pulse while not driven");

endmodule // clcr_speed_pulse

// file: design/clcr_regs.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ns
// Overview of operation
// R01: deceleration field used only with surge guard off and source select zero
// R02: deceleration code decodes a rising rate table, 0.5 to 1000 Hz/s and more
// R03: bit 14 picks continuous or discontinuous space vector modulation
// R04: speed pulse gate code 0 both loops, 1 closed only, 3 none
// R05: gate code 2 allows open loop pulses only in first run after wake; code also allows them in the first run after reset
// R06: speed pulses divided by bits 11-8, codes 0 and 1 divide by one
// R07: bit 7 set keeps pulses only until back-emf falls below level
// R08: cut-off level codes 0-5 give 1,2,5,10,20,30 mV; 6,7 unused
// R09: bit 3 enables the anti-voltage-surge guard
// R10: bit 2 enables dead-time compensation
// R11: bit 1 disables speed loop and selects torque mode
// R12: second register at index 8Ah, resets zero, stop and brake fields
// R13: select bit 24 takes deceleration from field or acceleration setting
// R14: stop option decodes 0,2,3,4,5; codes 1,6,7 undefined
// R15: written fields read back unchanged; reserved bits read zero
module clcr_regs (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [19:0] accel_rate_tenths,
    input wire logic motor_driven,
    input wire logic closed_loop,
    input wire logic run_start,
    input wire logic wake_event,
    input wire logic pulse_event,
    input wire logic [7:0] back_emf_mv,
    output logic [19:0] decel_rate_tenths,
    output logic decel_from_field,
    output logic [3:0] switching_freq_setting,
    output logic svm_discontinuous,
    output logic surge_guard_enable,
    output logic deadtime_comp_enable,
    output logic torque_mode_select,
    output logic [2:0] stop_option,
    output logic stop_option_valid,
    output logic [3:0] stop_brake_duration,
    output logic [7:0] phase_resistance,
    output logic [7:0] phase_inductance,
    output logic speed_pulse_output
);

    typedef struct packed {
        logic [31:0] reg_one;
        logic [31:0] reg_two;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [19:0] decel_rate;
        logic decel_from_field;
        logic [3:0] freq;
        logic svm_disc;
        logic surge;
        logic dead;
        logic torque;
        logic [2:0] stop;
        logic stop_valid;
        logic [3:0] brake;
        logic [7:0] res;
        logic [7:0] ind;
    } clcr_state_t;

    clcr_state_t state;
    clcr_state_t next_state;
    logic access;
    logic hit_one;
    logic hit_two;
    logic use_field;
    logic [4:0] decel_code;

    // ==========================================================
    // apb slave, one wait state, then field decode
    always_comb begin
        next_state = state;
        access = psel & penable;
        hit_one = (paddr == clcr_pkg::ADDR_ONE);
        hit_two = (paddr == clcr_pkg::ADDR_TWO);
        next_state.pready = 1'b0;
        next_state.pslverr = 1'b0;
        // first access cycle: answer is prepared
        if (access && !state.pready) begin
            next_state.pready = 1'b1;
            next_state.pslverr = ~(hit_one | hit_two);
            if (pwrite || !(hit_one | hit_two)) begin
                next_state.prdata = 32'h00000000;
            end else if (hit_one) begin
                next_state.prdata = state.reg_one; // R15
            end else begin
                next_state.prdata = state.reg_two; // R12 R15
            end
        end
        // completing edge: write takes effect
        if (access && state.pready && pwrite) begin
            if (hit_one) begin
                next_state.reg_one = clcr_pkg::merge(state.reg_one, pwdata,
                    pstrb, clcr_pkg::MASK_ONE); // R15
            end
            if (hit_two) begin
                next_state.reg_two = clcr_pkg::merge(state.reg_two, pwdata,
                    pstrb, clcr_pkg::MASK_TWO); // R12 R15
            end
        end

        // deceleration source
        use_field = ~state.reg_one[clcr_pkg::SURGE_BIT]
            & ~state.reg_one[clcr_pkg::DEC_SEL_BIT]; // R01 R13
        decel_code = state.reg_one[clcr_pkg::DEC_LSB +: 5];
        next_state.decel_from_field = use_field; // R01
        if (use_field) begin
            next_state.decel_rate = clcr_pkg::decel_tenths(decel_code); // R02
        end else begin
            next_state.decel_rate = accel_rate_tenths; // R13
        end

        // plain control fields
        next_state.freq = state.reg_one[clcr_pkg::FREQ_LSB +: 4];
        next_state.svm_disc = state.reg_one[clcr_pkg::MODE_BIT]; // R03
        next_state.surge = state.reg_one[clcr_pkg::SURGE_BIT]; // R09
        next_state.dead = state.reg_one[clcr_pkg::DEAD_BIT]; // R10
        next_state.torque = state.reg_one[clcr_pkg::TORQ_BIT]; // R11

        // stop option and second register fields
        next_state.stop = state.reg_two[clcr_pkg::STOP_LSB +: 3];
        unique case (state.reg_two[clcr_pkg::STOP_LSB +: 3])
            3'h0, 3'h2, 3'h3, 3'h4, 3'h5: next_state.stop_valid = 1'b1; // R14
            default: next_state.stop_valid = 1'b0; // R14
        endcase
        next_state.brake = state.reg_two[clcr_pkg::BRK_LSB +: 4]; // R12
        next_state.res = state.reg_two[clcr_pkg::RES_LSB +: 8];
        next_state.ind = state.reg_two[clcr_pkg::IND_LSB +: 8];
    end

    // state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '0;
            state.reg_one <= clcr_pkg::RST_ONE;
            state.reg_two <= clcr_pkg::RST_TWO; // R12
            state.decel_rate <= clcr_pkg::decel_tenths(5'h00);
            state.decel_from_field <= 1'b1;
            state.stop_valid <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // speed pulse path
    clcr_speed_pulse u_speed_pulse (
        .clock(clock),
        .resetn(resetn),
        .gate_select(state.reg_one[clcr_pkg::GATE_LSB +: 2]),
        .divider(state.reg_one[clcr_pkg::DIV_LSB +: 4]),
        .cutoff_mode(state.reg_one[clcr_pkg::CUT_MODE_BIT]),
        .cutoff_level(state.reg_one[clcr_pkg::CUT_LVL_LSB +: 3]),
        .motor_driven(motor_driven),
        .closed_loop(closed_loop),
        .run_start(run_start),
        .wake_event(wake_event),
        .pulse_event(pulse_event),
        .back_emf_mv(back_emf_mv),
        .speed_pulse_output(speed_pulse_output)
    );

    // outputs straight from the state register
    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign decel_rate_tenths = state.decel_rate;
    assign decel_from_field = state.decel_from_field;
    assign switching_freq_setting = state.freq;
    assign svm_discontinuous = state.svm_disc;
    assign surge_guard_enable = state.surge;
    assign deadtime_comp_enable = state.dead;
    assign torque_mode_select = state.torque;
    assign stop_option = state.stop;
    assign stop_option_valid = state.stop_valid;
    assign stop_brake_duration = state.brake;
    assign phase_resistance = state.res;
    assign phase_inductance = state.ind;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence acc_start;
        psel && penable && !pready;
    endsequence
    sequence wr_done_one;
        psel && penable && pready && pwrite && pstrb == 4'hF
        && paddr == clcr_pkg::ADDR_ONE;
    endsequence
    sequence rd_start_two;
        acc_start and (!pwrite && paddr == clcr_pkg::ADDR_TWO);
    endsequence

    apb_wait_a: assert property (acc_start |=> pready)
        else $error("no answer after one wait state");
    readback_one_a: assert property (wr_done_one |=> // R15
        state.reg_one == (($past(pwdata)) & clcr_pkg::MASK_ONE))
        else $error("first register did not store write");
    read_two_a: assert property (rd_start_two |=> // R12
        prdata == state.reg_two && !pslverr)
        else $error("second register read wrong");
    reserved_a: assert property ( // R15
        state.reg_one[0] == 1'b0 && state.reg_two[31] == 1'b0)
        else $error("reserved bit set");
    decel_src_a: assert property (##1 decel_from_field == // R01 R13
        (!$past(state.reg_one[clcr_pkg::SURGE_BIT])
        && !$past(state.reg_one[clcr_pkg::DEC_SEL_BIT])))
        else $error("deceleration source wrong");
    decel_tab_a: assert property ( // R02
        use_field && decel_code == 5'h13 |=> decel_rate_tenths == 20'd10000)
        else $error("deceleration code 13h not 1000 Hz/s");
    decel_acc_a: assert property (!use_field |=> // R13
        decel_rate_tenths == $past(accel_rate_tenths))
        else $error("acceleration rate not passed");
    mode_a: assert property (wr_done_one |-> ##2 // R03 R09
        svm_discontinuous == $past(pwdata[clcr_pkg::MODE_BIT], 2)
        && surge_guard_enable == $past(pwdata[clcr_pkg::SURGE_BIT], 2))
        else $error("modulation or surge guard not applied");
    dead_torque_a: assert property (wr_done_one |-> ##2 // R10 R11
        deadtime_comp_enable == $past(pwdata[clcr_pkg::DEAD_BIT], 2)
        && torque_mode_select == $past(pwdata[clcr_pkg::TORQ_BIT], 2))
        else $error("dead-time or torque mode not applied");
    stop_a: assert property ( // R14
        stop_option == 3'h1 |-> !stop_option_valid)
        else $error("undefined stop option flagged valid");
    unmapped_a: assert property (acc_start
        and (paddr != clcr_pkg::ADDR_ONE && paddr != clcr_pkg::ADDR_TWO)
        |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

endmodule // clcr_regs

// file: dv/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb_top;
    // ==========================================================
    // signals
    logic clock, resetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr;
    logic [19:0] accel_rate_tenths, decel_rate_tenths;
    logic motor_driven, closed_loop, run_start, wake_event, pulse_event;
    logic [7:0] back_emf_mv, phase_resistance, phase_inductance;
    logic decel_from_field, svm_discontinuous, surge_guard_enable;
    logic deadtime_comp_enable, torque_mode_select, stop_option_valid;
    logic speed_pulse_output;
    logic [3:0] switching_freq_setting, stop_brake_duration;
    logic [2:0] stop_option;
    logic [31:0] seed = 32'h3F77;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;

    clcr_regs dut (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .accel_rate_tenths(accel_rate_tenths), .motor_driven(motor_driven),
        .closed_loop(closed_loop), .run_start(run_start),
        .wake_event(wake_event), .pulse_event(pulse_event),
        .back_emf_mv(back_emf_mv), .decel_rate_tenths(decel_rate_tenths),
        .decel_from_field(decel_from_field),
        .switching_freq_setting(switching_freq_setting),
        .svm_discontinuous(svm_discontinuous),
        .surge_guard_enable(surge_guard_enable),
        .deadtime_comp_enable(deadtime_comp_enable),
        .torque_mode_select(torque_mode_select), .stop_option(stop_option),
        .stop_option_valid(stop_option_valid),
        .stop_brake_duration(stop_brake_duration),
        .phase_resistance(phase_resistance),
        .phase_inductance(phase_inductance),
        .speed_pulse_output(speed_pulse_output));

    // ==========================================================
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ==========================================================
    // expectation helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [19:0] dec_exp(input logic [4:0] c);
        logic [19:0] t [0:30];
        t = '{20'h5, 20'hA, 20'h19, 20'h32, 20'h4B, 20'h64, 20'hC8, 20'h190,
            20'h258, 20'h320, 20'h3E8, 20'h7D0, 20'hBB8, 20'hFA0, 20'h1388,
            20'h1770, 20'h1B58, 20'h1F40, 20'h2328, 20'h2710, 20'h4E20,
            20'h9C40, 20'hEA60, 20'h13880, 20'h186A0, 20'h30D40, 20'h493E0,
            20'h61A80, 20'h7A120, 20'h927C0, 20'hAAE60};
        return (c == 5'h1F) ? 20'hFFFFF : t[c];
    endfunction

    function automatic logic [7:0] thr(input int c);
        int t [0:5];
        t = '{1, 2, 5, 10, 20, 30};
        return 8'(t[c]);
    endfunction

    // ==========================================================
    // bus and stimulus tasks
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] w, input logic [3:0] s,
                       output logic [31:0] d, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        // no local limit: only the hang guard ends a stuck wait
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr1(input logic [31:0] w);
        logic [31:0] d;
        logic e;
        apb(1'b1, clcr_pkg::ADDR_ONE, w, 4'hF, d, e);
        repeat (2) @(posedge clock);
    endtask

    task automatic rst();
        resetn <= 1'b0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
    endtask

    task automatic pulses(input int n, output int c);
        c = 0;
        for (int i = 0; i <= n + 3; i++) begin
            @(posedge clock);
            if (speed_pulse_output === 1'b1) c++;
            pulse_event <= (i < n);
        end
    endtask

    task automatic newrun(input logic wk);
        motor_driven <= 1'b0;
        @(posedge clock);
        wake_event <= wk;
        @(posedge clock);
        wake_event <= 1'b0;
        motor_driven <= 1'b1;
        run_start <= 1'b1;
        @(posedge clock);
        run_start <= 1'b0;
        @(posedge clock);
    endtask

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] w, d;
        logic e, fld;
        int c, k;
        int dv [0:4];
        int gt [0:3];
        int cl [0:3];
        int ex [0:3];
        dv = '{0, 1, 2, 3, 15};
        gt = '{1, 3, 0, 1};
        cl = '{0, 1, 0, 1};
        ex = '{0, 0, 6, 6};
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {accel_rate_tenths, motor_driven, closed_loop} = '0;
        {run_start, wake_event, pulse_event, back_emf_mv} = '0;
        resetn = 1'b0;
        rst();
        `CHK("dec_rst", 20'h5, decel_rate_tenths)
        `CHK("src_rst", 1'b1, decel_from_field)
        `CHK("stop_v_rst", 1'b1, stop_option_valid)
        apb(1'b0, clcr_pkg::ADDR_TWO, 32'h0, 4'h0, d, e);
        `CHK("two_rst", 32'h0, d)
        // first register: random fields with corner decel codes
        for (int i = 0; i < 14; i++) begin
            w = xs();
            if (i < 3) begin
                w[24] = 1'b0;
                w[3] = 1'b0;
                w[23:19] = (i == 0) ? 5'h0 : (i == 1) ? 5'h13 : 5'h1F;
            end
            accel_rate_tenths <= 20'(xs());
            wr1(w);
            fld = !w[3] && !w[24];
            `CHK("src", fld, decel_from_field)
            `CHK("dec", fld ? dec_exp(w[23:19]) : accel_rate_tenths,
                 decel_rate_tenths)
            `CHK("svm", w[14], svm_discontinuous)
            `CHK("surge", w[3], surge_guard_enable)
            `CHK("dead", w[2], deadtime_comp_enable)
            `CHK("torq", w[1], torque_mode_select)
            `CHK("freq", w[18:15], switching_freq_setting)
            apb(1'b0, clcr_pkg::ADDR_ONE, 32'h0, 4'h0, d, e);
            `CHK("rd_one", w & 32'h01FFFFFE, d)
        end
        // second register: every stop code
        for (int i = 0; i < 8; i++) begin
            w = xs();
            w[30:28] = 3'(i);
            apb(1'b1, clcr_pkg::ADDR_TWO, w, 4'hF, d, e);
            repeat (2) @(posedge clock);
            apb(1'b0, clcr_pkg::ADDR_TWO, 32'h0, 4'h0, d, e);
            `CHK("rd_two", w & 32'h7FFFFFFF, d)
            `CHK("stop", 3'(i), stop_option)
            `CHK("stop_v", !(i == 1 || i == 6 || i == 7),
                 stop_option_valid)
            `CHK("brk", w[27:24], stop_brake_duration)
            `CHK("res", w[15:8], phase_resistance)
            `CHK("ind", w[7:0], phase_inductance)
        end
        // byte lanes and unmapped address
        apb(1'b1, clcr_pkg::ADDR_ONE, 32'hFFFFFFFF, 4'hF, d, e);
        apb(1'b1, clcr_pkg::ADDR_ONE, 32'h0, 4'h5, d, e);
        apb(1'b1, 12'h224, 32'h0, 4'hF, d, e);
        `CHK("err_wr", 1'b1, e)
        apb(1'b0, clcr_pkg::ADDR_ONE, 32'h0, 4'h0, d, e);
        `CHK("strb", 32'h0100FF00, d)
        apb(1'b0, 12'h224, 32'h0, 4'h0, d, e);
        `CHK("err_rd", 1'b1, e)
        `CHK("err_d", 32'h0, d)
        // divider codes
        motor_driven <= 1'b1;
        closed_loop <= 1'b1;
        foreach (dv[j]) begin
            rst();
            wr1(32'(dv[j]) << 8);
            pulses(30, c);
            k = (dv[j] < 2) ? 1 : dv[j];
            `CHK("div", 30 / k, c)
        end
        // gate codes against loop state
        foreach (gt[j]) begin
            closed_loop <= cl[j][0];
            wr1(32'(gt[j]) << 12);
            pulses(6, c);
            `CHK("gate", ex[j], c)
        end
        // first run after reset or wake only
        rst();
        closed_loop <= 1'b0;
        wr1(32'h2000);
        newrun(1'b0);
        pulses(4, c);
        `CHK("first", 4, c)
        newrun(1'b0);
        pulses(4, c);
        `CHK("later", 0, c)
        closed_loop <= 1'b1;
        pulses(4, c);
        `CHK("later_cl", 4, c)
        closed_loop <= 1'b0;
        newrun(1'b1);
        pulses(4, c);
        `CHK("wake", 4, c)
        // cut-off levels with motor not driven, then cut-off mode off with motor not driven and driven
        motor_driven <= 1'b0;
        closed_loop <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr1(32'h80 | (32'(i) << 4));
            back_emf_mv <= (i < 6) ? thr(i) : 8'hFF;
            pulses(3, c);
            `CHK("cut_hi", (i < 6) ? 3 : 0, c)
            back_emf_mv <= (i < 6) ? thr(i) - 8'h1 : 8'h0;
            pulses(3, c);
            `CHK("cut_lo", 0, c)
        end
        wr1(32'h30);
        back_emf_mv <= 8'hFF;
        pulses(3, c);
        `CHK("mode0_off", 0, c)
        motor_driven <= 1'b1;
        pulses(3, c);
        `CHK("mode0_on", 3, c)
        close_out();
    end
endmodule // tb_top
